/* File: core/activity_axis_compare.sv */
`timescale 1ns/1ns
`default_nettype none
`include "motion_event_consts.svh"

module activity_axis_compare #(
	parameter int SAMPLE_W = `SAMPLE_WIDTH,
	parameter int THRESH_W = 16
) (
	input  wire logic [SAMPLE_W-1:0] sample,
	input  wire logic [THRESH_W-1:0] threshold,
	input  wire logic                axisOn,
	output logic                     above
);

	logic [SAMPLE_W-1:0] magnitude;

	generate
		if (SAMPLE_W != `SAMPLE_WIDTH || THRESH_W != `SAMPLE_CMP_MSB - `SAMPLE_CMP_LSB + 1) begin : g_bad
			$error("activity_axis_compare: widths do not match the compare window");
		end
	endgenerate

	// Full-scale negative has no positive twin; its top bit marks it as above any threshold
	always_comb begin
		magnitude = sample[`SAMPLE_SIGN_BIT] ? SAMPLE_W'(~sample + 1'b1) : sample;
		above = axisOn && (magnitude[`SAMPLE_SIGN_BIT] ||
			magnitude[`SAMPLE_CMP_MSB:`SAMPLE_CMP_LSB] > threshold);
	end

endmodule
`default_nettype wire

/* File: core/motion_event_config_block.sv */
`timescale 1ns/1ns
`default_nettype none
`include "motion_event_consts.svh"

// How it works
// - An axis joins activity detection only when its select bit is set.
// - Threshold is sixteen bit unsigned, high and low bytes, both reset zero.
// - Only samples strictly above the threshold advance the run counter.
// - Threshold bit zero weighs the same as sample bit three.
// - Activity declared when consecutive run equals programmed count; count resets to one.
// - High-pass corner in filter bits six to four; zero disables, reset zero.
// - Corner codes one to six pick ever lower fractions of output rate.
// - Rate and low-pass code in bits three to zero, up to ten.
// - Watermark seven bits; full condition raised when stored count reaches it.
// - Watermark resets to 0x60, so before setup the full condition is raised only once the stored count reaches 96.
// - Each map bit routes one event source onto one pin independently.
// - Map bits seven to four route activity, overrun, watermark, ready to pin two.
// - Map bits three to zero route the same sources to pin one.
// - Polarity low gives active-low pins, high gives active-high pins.
// - Configure in standby; standby clears detection state and FIFO pointers.
module motion_event_config_block
	import motion_event_pkg::*;
#(
	parameter int SAMPLE_W = `SAMPLE_WIDTH,
	parameter int THRESH_W = 16
) (
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	input  wire logic [7:0]          regAddr,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	input  wire logic [7:0]          regWdata,
	output logic      [7:0]          regRdata,
	output logic                     regReadValid,
	input  wire logic                standby,
	input  wire logic                irqPolarity,
	input  wire logic                sampleValid,
	input  wire logic [SAMPLE_W-1:0] xAxisSample,
	input  wire logic [SAMPLE_W-1:0] yAxisSample,
	input  wire logic [SAMPLE_W-1:0] zAxisSample,
	input  wire logic                dataReady,
	input  wire logic                fifoOverrun,
	input  wire logic [6:0]          fifoSampleCount,
	output filter_s                  filterSettings,
	output logic                     highpassEnable,
	output logic                     fifoWatermarkHit,
	output logic                     activityDetected,
	output logic                     fifoPointerReset,
	output logic                     irqPinOne,
	output logic                     irqPinTwo
);

	// ****************************************
	// Parameter checks
	// ****************************************
	generate
		if (SAMPLE_W != `SAMPLE_WIDTH || THRESH_W != 16) begin : g_bad
			$error("motion_event_config_block: unsupported sample or threshold width");
		end
	endgenerate

	// ****************************************
	// Registers
	// ****************************************
	axis_select_s          axisSelect;
	logic [THRESH_W-1:0]   activityThreshold;
	logic [7:0]            activitySampleCount;
	filter_s               filterReg;
	logic [6:0]            watermarkLevel;
	pin_map_s              pinMap;
	logic [7:0]            runCount;
	logic [7:0]            next_runCount;
	logic                  xAbove;
	logic                  yAbove;
	logic                  zAbove;
	logic                  anyAbove;
	logic                  wmReach;
	event_s                events;
	logic                  assertOne;
	logic                  assertTwo;

	wire logic writeAxis   = regWrite && regAddr == `ADDR_AXIS_SELECT;
	wire logic writeHigh   = regWrite && regAddr == `ADDR_THRESHOLD_HIGH;
	wire logic writeLow    = regWrite && regAddr == `ADDR_THRESHOLD_LOW;
	wire logic writeCount  = regWrite && regAddr == `ADDR_SAMPLE_COUNT;
	wire logic writeFilter = regWrite && regAddr == `ADDR_FILTER;
	wire logic writeWm     = regWrite && regAddr == `ADDR_WATERMARK;
	wire logic writeMap    = regWrite && regAddr == `ADDR_PIN_MAP;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			axisSelect <= `RST_AXIS_SELECT;
		end else if (writeAxis) begin
			axisSelect <= regWdata[`AXIS_SEL_MSB:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			activityThreshold <= `RST_THRESHOLD;
		end else if (writeHigh) begin
			activityThreshold[15:8] <= regWdata;
		end else if (writeLow) begin
			activityThreshold[7:0] <= regWdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			activitySampleCount <= `RST_SAMPLE_COUNT;
		end else if (writeCount) begin
			activitySampleCount <= regWdata;
		end
	end

	// Corner may change during measurement; the filter picks it up on its next sample
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			filterReg <= `RST_FILTER;
		end else if (writeFilter) begin
			filterReg.highpassCornerSel <= regWdata[`HPF_MSB:`HPF_LSB];
			filterReg.rateLowpassSel    <= regWdata[`RATE_MSB:`RATE_LSB];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			watermarkLevel <= `RST_WATERMARK;
		end else if (writeWm) begin
			watermarkLevel <= regWdata[`WATERMARK_MSB:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pinMap <= `RST_PIN_MAP;
		end else if (writeMap) begin
			pinMap <= regWdata;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	// Unmapped offsets read zero; reserved bits read zero
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			regRdata <= 8'h00;
			regReadValid <= 1'b0;
		end else begin
			regReadValid <= regRead;
			if (regRead) begin
				case (regAddr)
					`ADDR_AXIS_SELECT:    regRdata <= {5'h00, axisSelect};
					`ADDR_THRESHOLD_HIGH: regRdata <= activityThreshold[15:8];
					`ADDR_THRESHOLD_LOW:  regRdata <= activityThreshold[7:0];
					`ADDR_SAMPLE_COUNT:   regRdata <= activitySampleCount;
					`ADDR_FILTER:         regRdata <= {1'b0, filterReg};
					`ADDR_WATERMARK:      regRdata <= {1'b0, watermarkLevel};
					`ADDR_PIN_MAP:        regRdata <= pinMap;
					default:              regRdata <= 8'h00;
				endcase
			end
		end
	end

	// ****************************************
	// Activity detection
	// ****************************************
	activity_axis_compare #(.SAMPLE_W(SAMPLE_W), .THRESH_W(THRESH_W)) u_cmp_x (
		.sample    (xAxisSample),
		.threshold (activityThreshold),
		.axisOn    (axisSelect.xAxisActivityInclude),
		.above     (xAbove)
	);

	activity_axis_compare #(.SAMPLE_W(SAMPLE_W), .THRESH_W(THRESH_W)) u_cmp_y (
		.sample    (yAxisSample),
		.threshold (activityThreshold),
		.axisOn    (axisSelect.yAxisActivityInclude),
		.above     (yAbove)
	);

	activity_axis_compare #(.SAMPLE_W(SAMPLE_W), .THRESH_W(THRESH_W)) u_cmp_z (
		.sample    (zAxisSample),
		.threshold (activityThreshold),
		.axisOn    (axisSelect.zAxisActivityInclude),
		.above     (zAbove)
	);

	always_comb begin
		anyAbove = xAbove || yAbove || zAbove;
		next_runCount = (runCount == `RUN_COUNT_MAX) ? runCount : runCount + 8'h01;
	end

	// Run counter saturates so a long run cannot wrap back to the trigger value
	always_ff @(posedge core_clk) begin
		if (!reset_n || standby) begin
			runCount <= 8'h00;
		end else if (sampleValid) begin
			if (anyAbove) begin
				runCount <= next_runCount;
			end else begin
				runCount <= 8'h00;
			end
		end
	end

	// Activity holds while the run lasts; a count of zero never triggers
	always_ff @(posedge core_clk) begin
		if (!reset_n || standby) begin
			activityDetected <= 1'b0;
		end else if (sampleValid) begin
			if (!anyAbove) begin
				activityDetected <= 1'b0;
			end else if (next_runCount == activitySampleCount) begin
				activityDetected <= 1'b1;
			end
		end
	end

	// ****************************************
	// Filter and FIFO outputs
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			filterSettings <= `RST_FILTER;
			highpassEnable <= 1'b0;
		end else begin
			filterSettings <= filterReg;
			highpassEnable <= filterReg.highpassCornerSel != `HPF_OFF;
		end
	end

	assign wmReach = !standby && fifoSampleCount >= watermarkLevel;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fifoWatermarkHit <= 1'b0;
			fifoPointerReset <= 1'b1;
		end else begin
			fifoWatermarkHit <= wmReach;
			fifoPointerReset <= standby;
		end
	end

	// ****************************************
	// Interrupt pins
	// ****************************************
	always_comb begin
		events.activity  = activityDetected;
		events.overrun   = fifoOverrun;
		events.watermark = fifoWatermarkHit;
		events.ready     = dataReady;
		assertOne = |(pinMap.toPinOne & events);
		assertTwo = |(pinMap.toPinTwo & events);
	end

	// Pins come up inactive for the default active-low polarity
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			irqPinOne <= 1'b1;
			irqPinTwo <= 1'b1;
		end else begin
			irqPinOne <= irqPolarity ? assertOne : !assertOne;
			irqPinTwo <= irqPolarity ? assertTwo : !assertTwo;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_axis_gate;
		sampleValid && !standby && axisSelect == 3'h0 |=> runCount == 8'h00 && !activityDetected;
	endproperty
	a_axis_gate: assert property (p_axis_gate) else $error("run counted with no axis selected");

	property p_reset_values;
		!$past(reset_n) |-> activityThreshold == 16'h0000 && axisSelect == 3'h0 && pinMap == 8'h00;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("threshold or map not zero after reset");

	property p_equal_not_counted;
		sampleValid && !standby && axisSelect == 3'h1 && xAxisSample[19:3] == {1'b0, activityThreshold}
			|=> runCount == 8'h00;
	endproperty
	a_equal_not_counted: assert property (p_equal_not_counted) else $error("equal sample counted");

	property p_above_counts;
		sampleValid && !standby && axisSelect == 3'h1 && !xAxisSample[19]
			&& xAxisSample[18:3] > activityThreshold && runCount != 8'hff
			|=> runCount == $past(runCount) + 8'h01;
	endproperty
	a_above_counts: assert property (p_above_counts) else $error("above sample not counted");

	property p_activity_after_count;
		sampleValid && !standby && anyAbove && next_runCount == activitySampleCount |=> activityDetected;
	endproperty
	a_activity_after_count: assert property (p_activity_after_count) else $error("activity missed");

	property p_count_reset;
		!$past(reset_n) |-> activitySampleCount == 8'h01 && filterReg == 7'h00;
	endproperty
	a_count_reset: assert property (p_count_reset) else $error("count or filter reset wrong");

	property p_hpf_enable;
		writeFilter |=> ##1 highpassEnable == ($past(regWdata[6:4], 2) != 3'h0);
	endproperty
	a_hpf_enable: assert property (p_hpf_enable) else $error("high-pass enable wrong");

	property p_rate_field;
		writeFilter |=> ##1 filterSettings.rateLowpassSel == $past(regWdata[3:0], 2);
	endproperty
	a_rate_field: assert property (p_rate_field) else $error("rate select wrong");

	property p_watermark;
		##1 fifoWatermarkHit == $past(wmReach);
	endproperty
	a_watermark: assert property (p_watermark) else $error("watermark condition wrong");

	property p_watermark_reset;
		!$past(reset_n) |-> watermarkLevel == 7'h60;
	endproperty
	a_watermark_reset: assert property (p_watermark_reset) else $error("watermark reset wrong");

	property p_pin_two_map;
		dataReady && pinMap == 8'h10 && !irqPolarity |=> !irqPinTwo && irqPinOne;
	endproperty
	a_pin_two_map: assert property (p_pin_two_map) else $error("pin two routing wrong");

	property p_pin_one_map;
		dataReady && pinMap == 8'h01 && !irqPolarity |=> !irqPinOne && irqPinTwo;
	endproperty
	a_pin_one_map: assert property (p_pin_one_map) else $error("pin one routing wrong");

	property p_polarity;
		##1 irqPinOne == ($past(irqPolarity) ? $past(assertOne) : !$past(assertOne));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin one level wrong");

	property p_standby_clears;
		standby |=> runCount == 8'h00 && !activityDetected && fifoPointerReset && !fifoWatermarkHit;
	endproperty
	a_standby_clears: assert property (p_standby_clears) else $error("standby did not clear");

	property p_or_sources;
		pinMap == 8'h0f && irqPolarity && (fifoOverrun || dataReady) |=> irqPinOne;
	endproperty
	a_or_sources: assert property (p_or_sources) else $error("pin one missed an enabled source");

	property p_run_cleared;
		sampleValid && !standby && !anyAbove |=> runCount == 8'h00 && !activityDetected;
	endproperty
	a_run_cleared: assert property (p_run_cleared) else $error("run not cleared");

	c_activity: cover property (sampleValid ##1 $rose(activityDetected));
	c_watermark: cover property ($rose(fifoWatermarkHit));
	c_pin_one: cover property (irqPolarity ##1 irqPinOne);
	c_read_map: cover property (regRead && regAddr == `ADDR_PIN_MAP ##1 regReadValid);

endmodule
`default_nettype wire

/* File: pkg/motion_event_consts.svh */
`ifndef MOTION_EVENT_CONSTS_SVH
`define MOTION_EVENT_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_AXIS_SELECT     8'h24
`define ADDR_THRESHOLD_HIGH  8'h25
`define ADDR_THRESHOLD_LOW   8'h26
`define ADDR_SAMPLE_COUNT    8'h27
`define ADDR_FILTER          8'h28
`define ADDR_WATERMARK       8'h29
`define ADDR_PIN_MAP         8'h2a

// ****************************************
// Reset values
// ****************************************
`define RST_AXIS_SELECT      3'h0
`define RST_THRESHOLD        16'h0000
`define RST_SAMPLE_COUNT     8'h01
`define RST_FILTER           7'h00
`define RST_WATERMARK        7'h60
`define RST_PIN_MAP          8'h00

// ****************************************
// Field positions and limits
// ****************************************
`define AXIS_SEL_MSB         2
`define HPF_MSB              6
`define HPF_LSB              4
`define RATE_MSB             3
`define RATE_LSB             0
`define WATERMARK_MSB        6
`define WATERMARK_MAX        7'h60
`define HPF_OFF              3'h0
`define SAMPLE_CMP_MSB       18
`define SAMPLE_CMP_LSB       3
`define SAMPLE_SIGN_BIT      19
`define SAMPLE_WIDTH         20
`define RUN_COUNT_MAX        8'hff

`endif

/* File: pkg/motion_event_pkg.sv */
package motion_event_pkg;

	// ****************************************
	// Event sources, in map bit order
	// ****************************************
	typedef struct packed {
		logic activity;
		logic overrun;
		logic watermark;
		logic ready;
	} event_s;

	typedef struct packed {
		event_s toPinTwo;
		event_s toPinOne;
	} pin_map_s;

	typedef struct packed {
		logic [2:0] highpassCornerSel;
		logic [3:0] rateLowpassSel;
	} filter_s;

	typedef struct packed {
		logic zAxisActivityInclude;
		logic yAxisActivityInclude;
		logic xAxisActivityInclude;
	} axis_select_s;

endpackage

/* File: testbench/host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Host side of the register bus
// ****************************************
module host_model (
	input  wire logic       core_clk,
	output logic      [7:0] regAddr,
	output logic            regWrite,
	output logic            regRead,
	output logic      [7:0] regWdata,
	output logic            standby
);
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 8'h00;
		standby = 1'b0;
	end

	// Released lines show the inverse, so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWdata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		regAddr <= ~a;
	endtask

	// Standby level alone, for checks of what standby clears
	task automatic hold(input logic on);
		@(posedge core_clk);
		standby <= on;
	endtask

	// Configuration only inside a standby window
	task automatic cfg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		standby <= 1'b1;
		wr(a, d);
		standby <= 1'b0;
	endtask
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "motion_event_consts.svh"

module testbench
	import motion_event_pkg::*;
;
	logic core_clk, reset_n, irqPolarity, sampleValid, dataReady, fifoOverrun;
	logic [7:0] regAddr, regWdata, regRdata;
	logic regWrite, regRead, regReadValid, standby;
	logic [19:0] xAxisSample, yAxisSample, zAxisSample;
	logic [6:0] fifoSampleCount;
	filter_s filterSettings;
	logic highpassEnable, fifoWatermarkHit, activityDetected, fifoPointerReset, irqPinOne, irqPinTwo;
	logic [7:0] expQ [$];
	int miscompares = 0;
	int compares = 0;
	logic [7:0] rstv [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h60, 8'h00};
	logic [7:0] mask [0:6] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff};
	logic [19:0] xs [0:7] = '{20'h0, 20'h0, 20'h0, 20'h40000, 20'h0, 20'h0, 20'h0, 20'h0};
	logic [19:0] ys [0:7] = '{20'h00818, 20'hff7e8, 20'h00817, 20'h0, 20'h00818, 20'h00818, 20'h00818, 20'h0};
	logic es [0:7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
		.regWdata(regWdata), .standby(standby));

	motion_event_config_block dut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
		.regReadValid(regReadValid), .standby(standby), .irqPolarity(irqPolarity),
		.sampleValid(sampleValid), .xAxisSample(xAxisSample), .yAxisSample(yAxisSample),
		.zAxisSample(zAxisSample), .dataReady(dataReady), .fifoOverrun(fifoOverrun),
		.fifoSampleCount(fifoSampleCount), .filterSettings(filterSettings),
		.highpassEnable(highpassEnable), .fifoWatermarkHit(fifoWatermarkHit),
		.activityDetected(activityDetected), .fifoPointerReset(fifoPointerReset),
		.irqPinOne(irqPinOne), .irqPinTwo(irqPinTwo));

	// ****************************************
	// Compare, closing and stimulus tasks
	// ****************************************
	task automatic chkVal(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chkBit(input string n, input logic e, input logic s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %b seen %b", n, e, s);
		end
	endtask

	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		host.rd(a);
	endtask

	task automatic smp(input logic [19:0] x, input logic [19:0] y, input logic e);
		@(posedge core_clk);
		sampleValid <= 1'b1;
		xAxisSample <= x;
		yAxisSample <= y;
		@(posedge core_clk);
		sampleValid <= 1'b0;
		#1;
		chkBit("activityDetected", e, activityDetected);
	endtask

	task automatic setsrc(input int k, input logic on);
		@(posedge core_clk);
		case (k)
			0: dataReady <= on;
			1: fifoSampleCount <= on ? 7'h0a : 7'h00;
			2: fifoOverrun <= on;
			default: yAxisSample <= on ? 20'h10000 : 20'h00000;
		endcase
	endtask

	// Read results are matched in issue order
	always @(negedge core_clk) begin
		if (regReadValid === 1'b1) begin
			chkVal("regRdata", (expQ.size() > 0) ? expQ.pop_front() : 8'hxx, regRdata);
		end
	end

	initial begin
		#200000;
		miscompares++;
		test_done();
	end

	initial begin
		logic [7:0] d;
		reset_n = 1'b0;
		{irqPolarity, sampleValid, dataReady, fifoOverrun} = 4'h0;
		{xAxisSample, yAxisSample, zAxisSample} = 60'h0;
		fifoSampleCount = 7'h00;
		void'($urandom(32'h8151d2ca));
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 7; i++) rdx(8'h24 + 8'(i), rstv[i]);
		rdx(8'h2b, 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 7; i++) begin
			d = (i == 5) ? 8'(1 + $urandom % 96) : 8'($urandom);
			host.cfg(8'h24 + 8'(i), d);
			rdx(8'h24 + 8'(i), d & mask[i]);
		end
		host.cfg(8'h2b, 8'hff);
		rdx(8'h2b, 8'h00);
		$display("test readback done");
		for (int h = 0; h < 7; h++) begin
			for (int r = 0; r < 11; r++) begin
				host.cfg(`ADDR_FILTER, {1'b0, 3'(h), 4'(r)});
				@(posedge core_clk);
				#1;
				chkVal("filterSettings", {1'b0, 3'(h), 4'(r)}, {1'b0, filterSettings});
				chkBit("highpassEnable", h != 0, highpassEnable);
			end
		end
		$display("test filter done");
		host.cfg(`ADDR_THRESHOLD_HIGH, 8'h01);
		host.cfg(`ADDR_THRESHOLD_LOW, 8'h02);
		host.cfg(`ADDR_SAMPLE_COUNT, 8'h03);
		// No axis, then x alone, then y alone; y stays on for the pin tests
		for (int a = 0; a < 3; a++) begin
			host.cfg(`ADDR_AXIS_SELECT, (a == 0) ? 8'h00 : (a == 1) ? 8'h01 : 8'h02);
			for (int i = 0; i < 8; i++) begin
				smp((a == 1) ? ys[i] : xs[i], (a == 1) ? xs[i] : ys[i], es[i] && a != 0);
			end
		end
		$display("test activity done");
		host.cfg(`ADDR_WATERMARK, 8'h0a);
		for (int c = 9; c < 11; c++) begin
			@(posedge core_clk);
			fifoSampleCount <= 7'(c);
			@(posedge core_clk);
			#1;
			chkBit("fifoWatermarkHit", c == 10, fifoWatermarkHit);
		end
		host.hold(1'b1);
		@(posedge core_clk);
		#1;
		chkBit("fifoPointerReset", 1'b1, fifoPointerReset);
		chkBit("fifoWatermarkHit", 1'b0, fifoWatermarkHit);
		host.hold(1'b0);
		@(posedge core_clk);
		fifoSampleCount <= 7'h00;
		sampleValid <= 1'b1;
		#1;
		chkBit("fifoPointerReset", 1'b0, fifoPointerReset);
		$display("test watermark done");
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				@(posedge core_clk);
				irqPolarity <= p[0];
				host.cfg(`ADDR_PIN_MAP, 8'h01 << i);
				setsrc(i % 4, 1'b1);
				repeat (6) @(posedge core_clk);
				#1;
				chkBit("irqPinOne", (i < 4) ? p[0] : !p[0], irqPinOne);
				chkBit("irqPinTwo", (i >= 4) ? p[0] : !p[0], irqPinTwo);
				setsrc(i % 4, 1'b0);
				repeat (6) @(posedge core_clk);
				#1;
				chkBit("irqPinOne", !p[0], irqPinOne);
				chkBit("irqPinTwo", !p[0], irqPinTwo);
			end
		end
		$display("test pin routing done");
		host.cfg(`ADDR_PIN_MAP, 8'h0f);
		setsrc(0, 1'b1);
		setsrc(2, 1'b1);
		for (int s = 0; s < 3; s++) begin
			repeat (2) @(posedge core_clk);
			#1;
			chkBit("irqPinOne", s < 2, irqPinOne);
			chkBit("irqPinTwo", 1'b0, irqPinTwo);
			setsrc(2 * s, 1'b0);
		end
		$display("test pin sources done");
		repeat (3) @(posedge core_clk);
		chkVal("pendingReads", 8'h00, 8'(expQ.size()));
		test_done();
	end
endmodule

`default_nettype wire
